// File: rtl/logic_lut.sv
// Configurable logic blocks with truth tables behind an AHB-Lite slave
`timescale 1ns/1ns

module logic_lut
	import logic_lut_pkg::*;
(
	// Clock, reset and clock enable
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Source signals and block outputs
	input wire logic [logic_lut_pkg::NUM_SOURCES-1:0] source_in,
	output logic [logic_lut_pkg::NUM_BLOCKS-1:0] block_out
);
	import logic_lut_pkg::*;

	// Configuration storage, per block and per input
	logic [BLK_W-1:0] block_choice_reg;
	logic [INP_W-1:0] input_choice_reg;
	logic [SEL_W-1:0] source_reg [NUM_BLOCKS][NUM_INPUTS];
	logic invert_reg [NUM_BLOCKS][NUM_INPUTS];
	logic [NUM_BLOCKS-1:0] function_reg;
	logic [NUM_BLOCKS-1:0] table_choice_reg;
	logic [IDX_W-1:0] index_reg [NUM_BLOCKS];
	// Two tables per block: data table and enable table
	logic [TABLE_SIZE-1:0] table_reg [NUM_BLOCKS][2];
	// Block output, latched flop and previous clock level
	logic [NUM_BLOCKS-1:0] out_reg;
	logic [NUM_BLOCKS-1:0] latch_reg;
	logic [NUM_BLOCKS-1:0] clk_prev_reg;

	// Bus pipeline state
	logic wr_pend_reg;
	logic rd_pend_reg;
	logic rd_done_reg;
	logic [7:0] addr_reg;
	logic [31:0] hrdata_reg;

	// Address phase decode
	wire logic addr_phase;
	wire logic wr_start;
	wire logic rd_start;
	wire logic wr_commit;
	assign addr_phase = hsel & htrans[1] & hready & clk_en;
	assign wr_start = addr_phase & hwrite;
	assign rd_start = addr_phase & ~hwrite;
	// A write lands at the end of the data phase that follows
	assign wr_commit = wr_pend_reg & clk_en;

	// Reads take one wait cycle so that hrdata comes from a flop
	assign hreadyout = clk_en & ~(rd_pend_reg & ~rd_done_reg);
	// Every transfer gets an OKAY response
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;
	// Block outputs come straight from flops
	assign block_out = out_reg;

	// Selected block, input and table for register access
	wire logic [BLK_W-1:0] blk;
	wire logic [INP_W-1:0] inp;
	wire logic tsel;
	wire logic [IDX_W-1:0] sel_index;
	wire logic [SEL_W-1:0] sel_source;
	wire logic sel_const;
	wire logic [TABLE_SIZE-1:0] sel_table;
	assign blk = block_choice_reg;
	assign inp = input_choice_reg;
	// Table choice only matters in the latched function
	assign tsel = (function_reg[blk] == FUNC_LATCHED)
		? table_choice_reg[blk] : TABLE_DATA;
	// Index, source and table of the current selection
	assign sel_index = index_reg[blk];
	assign sel_source = source_reg[blk][inp];
	// Constant sources take no invert setting
	assign sel_const = (sel_source == SRC_TRUE)
		| (sel_source == SRC_FALSE);
	assign sel_table = table_reg[blk][tsel];

	// Write strobes per register
	wire logic wr_blkc;
	wire logic wr_inpc;
	wire logic wr_src;
	wire logic wr_inv;
	wire logic wr_func;
	wire logic wr_tch;
	wire logic wr_idx;
	wire logic wr_ent;
	wire logic wr_word;
	// One strobe per register offset except the read-only block output
	assign wr_blkc = wr_commit & (addr_reg == OFS_BLOCK_CHOICE);
	assign wr_inpc = wr_commit & (addr_reg == OFS_INPUT_CHOICE);
	assign wr_src = wr_commit & (addr_reg == OFS_SOURCE_SELECT);
	// Invert is not offered for a constant source
	assign wr_inv = wr_commit & (addr_reg == OFS_INPUT_INVERT)
		& ~sel_const;
	assign wr_func = wr_commit & (addr_reg == OFS_BLOCK_FUNCTION);
	assign wr_tch = wr_commit & (addr_reg == OFS_TABLE_CHOICE);
	assign wr_idx = wr_commit & (addr_reg == OFS_TABLE_INDEX);
	assign wr_ent = wr_commit & (addr_reg == OFS_TABLE_ENTRY);
	assign wr_word = wr_commit & (addr_reg == OFS_TABLE_WORD);

	// Read data mux; unmapped offsets read zero
	logic [31:0] rd_mux;
	always_comb
	begin
		// Bits above each field stay zero
		rd_mux = RDATA_RESET;
		unique case (addr_reg)
			OFS_BLOCK_CHOICE: rd_mux[BLK_W-1:0] = block_choice_reg;
			OFS_INPUT_CHOICE: rd_mux[INP_W-1:0] = input_choice_reg;
			OFS_SOURCE_SELECT: rd_mux[SEL_W-1:0] = sel_source;
			// Constant source shows no invert
			OFS_INPUT_INVERT: rd_mux[0] = invert_reg[blk][inp]
				& ~sel_const;
			OFS_BLOCK_FUNCTION: rd_mux[0] = function_reg[blk];
			OFS_TABLE_CHOICE: rd_mux[0] = table_choice_reg[blk];
			OFS_TABLE_INDEX: rd_mux[IDX_W-1:0] = sel_index;
			OFS_TABLE_ENTRY: rd_mux[0] = sel_table[sel_index];
			OFS_TABLE_WORD: rd_mux[TABLE_SIZE-1:0] = sel_table;
			OFS_BLOCK_OUTPUT: rd_mux[NUM_BLOCKS-1:0] = out_reg;
			default: rd_mux = RDATA_RESET;
		endcase
	end

	// Bus phase tracking
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			rd_done_reg <= 1'b0;
			addr_reg <= OFS_BLOCK_CHOICE;
			hrdata_reg <= RDATA_RESET;
		end
		else if (clk_en)
		begin
			// New address phase only when the bus is ready
			if (hready)
			begin
				wr_pend_reg <= wr_start;
				rd_pend_reg <= rd_start;
				rd_done_reg <= 1'b0;
				if (addr_phase)
					addr_reg <= {haddr[7:2], 2'b00};
			end
			// First read data cycle loads the read flop
			else if (rd_pend_reg)
			begin
				rd_done_reg <= 1'b1;
				hrdata_reg <= rd_mux;
			end
		end
	end

	// Selector registers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			block_choice_reg <= '0;
			input_choice_reg <= '0;
		end
		else
		begin
			if (wr_blkc)
				block_choice_reg <= hwdata[BLK_W-1:0];
			if (wr_inpc)
				input_choice_reg <= hwdata[INP_W-1:0];
		end
	end

	// Per-block logic
	genvar b;
	genvar i;
	generate
		for (b = 0; b < NUM_BLOCKS; b++)
		begin : g_blk
			// Conditioned table inputs, input 0 is the index LSB
			logic [NUM_INPUTS-1:0] cond;
			for (i = 0; i < NUM_INPUTS; i++)
			begin : g_in
				wire logic [SEL_W-1:0] s;
				wire logic [SEL_W-1:0] k;
				wire logic raw;
				assign s = source_reg[b][i];
				// Position of the code within the source list
				assign k = s - SRC_FIRST;
				// Codes past the source list read low
				assign raw = (s >= SRC_FIRST)
					&& (k < SEL_W'(NUM_SOURCES))
					? source_in[k[2:0]] : 1'b0;
				// Constants bypass the inverter
				assign cond[i] = (s == SRC_TRUE) ? 1'b1
					: (s == SRC_FALSE) ? 1'b0
					: raw ^ invert_reg[b][i];
			end

			// Lookup at the conditioned index
			wire logic data_bit;
			wire logic en_bit;
			wire logic clk_edge;
			assign data_bit = table_reg[b][TABLE_DATA][cond];
			assign en_bit = table_reg[b][TABLE_ENABLE][cond];
			// Rising edge of the conditioned clock input
			assign clk_edge = cond[CLOCK_INPUT]
				& ~clk_prev_reg[b];

			// Block addressed by software, and its table for access
			wire logic me;
			wire logic tc;
			assign me = (blk == BLK_W'(b));
			assign tc = (function_reg[b] == FUNC_LATCHED)
				? table_choice_reg[b] : TABLE_DATA;

			// Configuration writes for this block
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
				begin
					function_reg[b] <= FUNC_COMB;
					table_choice_reg[b] <= TABLE_DATA;
					index_reg[b] <= '0;
					table_reg[b][TABLE_DATA] <= TABLE_RESET;
					table_reg[b][TABLE_ENABLE] <= TABLE_RESET;
					for (int n = 0; n < NUM_INPUTS; n++)
					begin
						source_reg[b][n] <= SRC_FALSE;
						invert_reg[b][n] <= 1'b0;
					end
				end
				else if (me)
				begin
					// Source and invert of the chosen input
					if (wr_src)
						source_reg[b][inp] <= hwdata[SEL_W-1:0];
					if (wr_inv)
						invert_reg[b][inp] <= hwdata[0];
					if (wr_func)
						function_reg[b] <= hwdata[0];
					if (wr_tch)
						table_choice_reg[b] <= hwdata[0];
					if (wr_idx)
						index_reg[b] <= hwdata[IDX_W-1:0];
					// Whole table in one access, index ignored
					if (wr_word)
						table_reg[b][tc] <= hwdata[TABLE_SIZE-1:0];
					else if (wr_ent)
						table_reg[b][tc][index_reg[b]] <= hwdata[0];
				end
			end

			// Latched flop and registered output
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
				begin
					latch_reg[b] <= 1'b0;
					clk_prev_reg[b] <= 1'b0;
					out_reg[b] <= 1'b0;
				end
				else if (clk_en)
				begin
					// Remember the clock level for edge detection
					clk_prev_reg[b] <= cond[CLOCK_INPUT];
					// Capture only on enabled active edge
					if (clk_edge & en_bit)
						latch_reg[b] <= data_bit;
					// Latched function shows the flop, else the lookup
					out_reg[b] <= (function_reg[b] == FUNC_LATCHED)
						? latch_reg[b] : data_bit;
				end
			end
		end
	endgenerate
endmodule

// File: rtl/logic_lut_pkg.sv
// Constants shared by the configurable logic block design
package logic_lut_pkg;
	// Structure of the logic blocks
	localparam int NUM_BLOCKS = 2;
	localparam int NUM_INPUTS = 4;
	localparam int TABLE_SIZE = 1 << NUM_INPUTS;
	localparam int NUM_SOURCES = 8;
	localparam int SEL_W = 4;
	localparam int IDX_W = NUM_INPUTS;
	localparam int BLK_W = 1;
	localparam int INP_W = 2;
	// Input that clocks the latched function
	localparam int CLOCK_INPUT = NUM_INPUTS - 1;
	// Source selection codes
	localparam logic [SEL_W-1:0] SRC_FALSE = 4'h0;
	localparam logic [SEL_W-1:0] SRC_TRUE = 4'h1;
	localparam logic [SEL_W-1:0] SRC_FIRST = 4'h2;
	// Block functions
	localparam logic FUNC_COMB = 1'b0;
	localparam logic FUNC_LATCHED = 1'b1;
	// Table choice values
	localparam logic TABLE_DATA = 1'b0;
	localparam logic TABLE_ENABLE = 1'b1;
	// Register byte offsets
	localparam logic [7:0] OFS_BLOCK_CHOICE = 8'h00;
	localparam logic [7:0] OFS_INPUT_CHOICE = 8'h04;
	localparam logic [7:0] OFS_SOURCE_SELECT = 8'h08;
	localparam logic [7:0] OFS_INPUT_INVERT = 8'h0C;
	localparam logic [7:0] OFS_BLOCK_FUNCTION = 8'h10;
	localparam logic [7:0] OFS_TABLE_CHOICE = 8'h14;
	localparam logic [7:0] OFS_TABLE_INDEX = 8'h18;
	localparam logic [7:0] OFS_TABLE_ENTRY = 8'h1C;
	localparam logic [7:0] OFS_TABLE_WORD = 8'h20;
	localparam logic [7:0] OFS_BLOCK_OUTPUT = 8'h24;
	// Reset values
	localparam logic [TABLE_SIZE-1:0] TABLE_RESET = 16'h0000;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
	// AHB encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

// File: tb/logic_lut_sva.sv
// Checker of bus timing and output stability
`timescale 1ns/1ns
module logic_lut_sva
	import logic_lut_pkg::*;
(
	// Clock, reset, enable
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	// Bus
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	// Logic side
	input wire logic [logic_lut_pkg::NUM_SOURCES-1:0] source_in,
	input wire logic [logic_lut_pkg::NUM_BLOCKS-1:0] block_out
);
	logic wr_reg; // Write data phase open
	logic [2:0] quiet_reg; // Cycles without activity
	logic [NUM_SOURCES-1:0] src_reg; // Previous sources
	wire take = hsel & htrans[1] & hready & clk_en; // Transfer taken
	wire hush = wr_reg | !clk_en | (source_in != src_reg); // Activity
	wire [2:0] quiet_next = hush ? 3'h0 : quiet_reg + {2'h0, quiet_reg != 3'h4};
	// Track write phases and quiet time
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_reg <= 1'b0;
			quiet_reg <= 3'h0;
			src_reg <= '0;
		end
		else
		begin
			wr_reg <= take ? hwrite : wr_reg & !hready;
			quiet_reg <= quiet_next;
			src_reg <= source_in;
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_read_wait; take && !hwrite |=> !hreadyout; endproperty
	a_read_wait: assert property (p_read_wait) else $error("no wait");
	property p_read_done; take && !hwrite ##1 clk_en[*2] |-> hreadyout;
	endproperty
	a_read_done: assert property (p_read_done) else $error("late");
	property p_write_go; take && hwrite |=> hreadyout || !clk_en; endproperty
	a_write_go: assert property (p_write_go) else $error("wr wait");
	property p_stall; !clk_en |-> !hreadyout; endproperty
	a_stall: assert property (p_stall) else $error("ready");
	property p_freeze; !clk_en |=> $stable(block_out); endproperty
	a_freeze: assert property (p_freeze) else $error("moved");
	property p_quiet; quiet_reg == 3'h4 |-> $stable(block_out); endproperty
	a_quiet: assert property (p_quiet) else $error("drift");
	property p_okay; hresp == 1'b0; endproperty
	a_okay: assert property (p_okay) else $error("resp");
	property p_rdata; !(clk_en && !hreadyout) |=> $stable(hrdata); endproperty
	a_rdata: assert property (p_rdata) else $error("rdata");
endmodule
bind logic_lut logic_lut_sva chk (.hclk(hclk), .hresetn(hresetn),
	.clk_en(clk_en), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .source_in(source_in), .block_out(block_out));

// File: tb/logic_lut_tb.sv
// Bench for the configurable logic blocks over AHB-Lite
`timescale 1ns/1ns
`define CHK(n, e, a) \
	begin \
		checks++; \
		if ((a) !== (e)) \
		begin \
			failures++; \
			$display("[FAIL] %s exp %0h got %0h", n, e, a); \
		end \
	end
module logic_lut_tb;
	import logic_lut_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic clk_en = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = '0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = '0;
	logic [7:0] source_in = '0;
	wire hreadyout;
	wire hresp;
	wire [31:0] hrdata;
	wire [1:0] block_out;
	int checks = 0; // Comparisons made
	int failures = 0; // Mismatches seen
	logic [15:0] tbl; // Table under test
	logic [3:0] idx; // Expected lookup index
	logic [31:0] q; // Last read data
	logic_lut uut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.source_in(source_in), .block_out(block_out));
	// 25 MHz clock
	always #20 hclk = ~hclk;
	// One word transfer; waits on ready in both phases
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		`CHK($sformatf("reg %0h", a), e, q)
	endtask
	// Route one input of the chosen block
	task automatic src(input logic [1:0] i, input logic [3:0] c);
		wr(OFS_INPUT_CHOICE, {30'h0, i});
		wr(OFS_SOURCE_SELECT, {28'h0, c});
	endtask
	// Set sources and let outputs settle
	task automatic drive(input logic [7:0] s);
		source_in <= s;
		repeat (3) @(posedge hclk);
	endtask
	task automatic summarize;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Watchdog
	initial
	begin
		repeat (20000) @(posedge hclk);
		failures++;
		summarize();
	end
	initial
	begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(OFS_BLOCK_FUNCTION, 32'h0);
		rd(OFS_SOURCE_SELECT, 32'h0);
		rd(8'h3C, 32'h0);
		$display("test reset done");
		tbl = 16'hA5C3;
		wr(OFS_TABLE_WORD, {16'hFFFF, tbl});
		rd(OFS_TABLE_WORD, {16'h0, tbl});
		for (int k = 0; k < 16; k++)
		begin
			wr(OFS_TABLE_INDEX, 32'(k));
			rd(OFS_TABLE_ENTRY, {31'h0, tbl[k]});
		end
		wr(OFS_TABLE_INDEX, 32'h2);
		wr(OFS_TABLE_ENTRY, 32'h1);
		rd(OFS_TABLE_WORD, 32'hA5C7);
		tbl = 16'h4A3D;
		wr(OFS_TABLE_WORD, {16'h0, tbl});
		rd(OFS_TABLE_INDEX, 32'h2);
		$display("test table done");
		for (int c = 0; c < 2; c++)
		begin
			for (int i = 0; i < 4; i++)
				src(i[1:0], c[3:0]);
			drive(8'h0);
			`CHK("block_out", tbl[c * 15], block_out[0])
		end
		wr(OFS_INPUT_CHOICE, 32'h1);
		wr(OFS_INPUT_INVERT, 32'h1);
		rd(OFS_INPUT_INVERT, 32'h0);
		src(2'h1, SRC_FIRST + 4'h1);
		rd(OFS_INPUT_INVERT, 32'h0);
		src(2'h1, SRC_TRUE);
		src(2'h2, 4'hF);
		src(2'h3, SRC_FIRST + 4'h3);
		src(2'h0, SRC_FIRST);
		for (int v = 0; v < 2; v++)
		begin
			wr(OFS_INPUT_INVERT, 32'(v));
			for (int s = 0; s < 4; s++)
			begin
				drive({4'h2, s[1], 2'h0, s[0]});
				idx = {s[1], 2'h1, s[0] ^ v[0]};
				`CHK("block_out", tbl[idx], block_out[0])
			end
		end
		clk_en <= 1'b0;
		drive(8'h0);
		`CHK("frozen", tbl[idx], block_out[0])
		clk_en <= 1'b1;
		drive(8'h0);
		rd(OFS_BLOCK_OUTPUT, {31'h0, tbl[3]});
		$display("test lookup done");
		wr(OFS_BLOCK_CHOICE, 32'h1);
		wr(OFS_BLOCK_FUNCTION, 32'h1);
		src(2'h3, SRC_FIRST + 4'h3);
		wr(OFS_TABLE_WORD, 32'hFFFF);
		wr(OFS_TABLE_CHOICE, 32'h1);
		rd(OFS_TABLE_WORD, 32'h0);
		drive(8'h08);
		`CHK("held", 1'b0, block_out[1])
		drive(8'h00);
		wr(OFS_TABLE_WORD, 32'hFFFF);
		drive(8'h08);
		`CHK("captured", 1'b1, block_out[1])
		wr(OFS_TABLE_CHOICE, 32'h0);
		rd(OFS_TABLE_WORD, 32'hFFFF);
		wr(OFS_TABLE_WORD, 32'h0);
		wr(OFS_INPUT_INVERT, 32'h1);
		drive(8'h08);
		`CHK("no edge", 1'b1, block_out[1])
		drive(8'h00);
		`CHK("falling", 1'b0, block_out[1])
		wr(OFS_TABLE_WORD, 32'hFFFF);
		drive(8'h08);
		`CHK("rising", 1'b0, block_out[1])
		$display("test latched done");
		summarize();
	end
endmodule
